// *** picm_counter.sv ***
/*
 * One programmable down-counting timer channel with six output modes,
 * read and forced-level reset operations, binary or BCD counting and a
 * choice of four count clock sources.
 * Assumes all inputs, including count clocks and gate, are synchronous to
 * i_clk_sys and that count clocks run well below the system clock.
 */

// What this block does
// - One-shot mode drives the output low after a gate rise and the next count clock fall, and high again at terminal count.
// - Rate generator mode pulses the output low for one count clock period, with the loaded count setting the pulse spacing.
// - With binary counting, square wave mode holds the output high for half the loaded count, rounded up, and low for the rest, repeating.
// - Software strobe mode starts with the output high and counts only while the gate is high.
// - Software strobe mode drives the output low for one count clock at terminal count, then high again.
// - Hardware strobe mode behaves like software strobe mode but a gate rising edge starts the count.
// - The requested output level applies only to the reset operation, low for 0 and high for 1.
// - The counter counts as 16-bit binary when the select is 1 and as four-decade BCD when 0.
// - The count clock comes from the external clock, previous counter, internal clock or counter ten by select 0 to 3.
// - The read operation returns the current count value to the requester.
// - Operation codes 0 to 5 pick the output modes, 6 reads and 7 resets, with mode 0 going high at terminal count.
module picm_counter
    import picm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire picm_cmd_t i_cmd,
    input wire logic i_external_count_clock,
    input wire logic i_previous_counter_output,
    input wire logic i_internal_count_clock,
    input wire logic i_counter_ten_output,
    input wire logic i_gate,
    output logic o_out,
    output logic o_tc_pulse,
    output logic o_read_valid,
    output logic [15:0] o_read_value
);

    // Decrement with wrap, in binary or BCD
    function automatic logic [15:0] dec_cnt(input logic [15:0] v,
                                            input logic bin);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        if (bin) begin
            r = v - PICM_CNT_ONE;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (v[d*4 +: 4] == PICM_DIGIT_ZERO) begin
                        r[d*4 +: 4] = PICM_DIGIT_NINE;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - PICM_DIGIT_ONE;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    picm_mode_t mode_r;
    logic binary_r;
    logic [1:0] src_r;
    logic [15:0] load_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic armed_r;
    logic half_r;
    logic cclk_prev_r;
    logic gate_prev_r;
    logic cclk;
    logic cclk_fall;
    logic gate_rise;
    logic at_tc;
    logic run;

    always_comb begin
        unique case (src_r)
            PICM_SRC_EXT: cclk = i_external_count_clock;
            PICM_SRC_PREV: cclk = i_previous_counter_output;
            PICM_SRC_INT: cclk = i_internal_count_clock;
            PICM_SRC_TEN: cclk = i_counter_ten_output;
        endcase
    end

    assign cclk_fall = cclk_prev_r & ~cclk;
    assign gate_rise = i_gate & ~gate_prev_r;
    // Next value wraps through zero, so terminal count is the one-count
    assign cnt_nxt = dec_cnt(cnt_r, binary_r);
    // Load 0 runs the full range before the one-count step
    assign at_tc = (cnt_r == PICM_CNT_ONE);

    always_comb begin
        run = 1'b0;
        unique case (mode_r)
            PICM_MODE0: run = armed_r & i_gate;
            PICM_MODE_ONESHOT: run = armed_r;
            PICM_MODE_RATE: run = i_gate;
            PICM_MODE_SQUARE: run = i_gate;
            PICM_MODE_SW_STROBE: run = armed_r & i_gate;
            PICM_MODE_HW_STROBE: run = armed_r;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cclk_prev_r <= 1'b0;
            gate_prev_r <= 1'b0;
        end else begin
            cclk_prev_r <= cclk;
            gate_prev_r <= i_gate;
        end
    end

    // Configuration taken from mode commands only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mode_r <= PICM_MODE0;
            binary_r <= PICM_BINARY_DEFAULT;
            src_r <= PICM_SRC_EXT;
            load_r <= PICM_CNT_ZERO;
        end else if (i_cmd_valid && i_cmd.op <= PICM_OP_HW_STROBE) begin
            binary_r <= i_cmd.binary_sel;
            src_r <= i_cmd.clk_src;
            load_r <= i_cmd.count;
            unique case (i_cmd.op)
                PICM_OP_MODE0: mode_r <= PICM_MODE0;
                PICM_OP_ONESHOT: mode_r <= PICM_MODE_ONESHOT;
                PICM_OP_RATE: mode_r <= PICM_MODE_RATE;
                PICM_OP_SQUARE: mode_r <= PICM_MODE_SQUARE;
                PICM_OP_SW_STROBE: mode_r <= PICM_MODE_SW_STROBE;
                default: mode_r <= PICM_MODE_HW_STROBE;
            endcase
        end
    end

    // Count, arm and output sequencing
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_r <= PICM_CNT_ZERO;
            armed_r <= 1'b0;
            half_r <= 1'b0;
            o_out <= PICM_OUT_IDLE;
            o_tc_pulse <= 1'b0;
        end else begin
            o_tc_pulse <= 1'b0;
            if (i_cmd_valid && i_cmd.op == PICM_OP_RESET) begin
                o_out <= i_cmd.out_level;
                armed_r <= 1'b0;
            end else if (i_cmd_valid && i_cmd.op <= PICM_OP_HW_STROBE) begin
                cnt_r <= i_cmd.count;
                half_r <= 1'b0;
                unique case (i_cmd.op)
                    PICM_OP_MODE0: begin
                        o_out <= 1'b0;
                        armed_r <= 1'b1;
                    end
                    PICM_OP_ONESHOT, PICM_OP_HW_STROBE: begin
                        o_out <= 1'b1;
                        armed_r <= 1'b0;
                    end
                    default: begin
                        o_out <= 1'b1;
                        armed_r <= 1'b1;
                    end
                endcase
            end else begin
                if ((mode_r == PICM_MODE_ONESHOT ||
                     mode_r == PICM_MODE_HW_STROBE) && gate_rise) begin
                    armed_r <= 1'b1;
                    cnt_r <= load_r;
                end
                if (mode_r == PICM_MODE_ONESHOT && armed_r && cclk_fall
                    && cnt_r == load_r) begin
                    o_out <= 1'b0;
                end
                if ((mode_r == PICM_MODE_SW_STROBE ||
                     mode_r == PICM_MODE_HW_STROBE) && cclk_fall &&
                    !o_out) begin
                    o_out <= 1'b1;
                end
                if (run && cclk_fall) begin
                    cnt_r <= cnt_nxt;
                    if (at_tc) begin
                        o_tc_pulse <= 1'b1;
                    end
                    unique case (mode_r)
                        PICM_MODE0, PICM_MODE_ONESHOT: begin
                            if (at_tc) begin
                                o_out <= 1'b1;
                                armed_r <= 1'b0;
                            end
                        end
                        PICM_MODE_RATE: begin
                            if (at_tc) begin
                                o_out <= 1'b0;
                                cnt_r <= load_r;
                            end else begin
                                o_out <= 1'b1;
                            end
                        end
                        PICM_MODE_SQUARE: begin
                            // Binary halving, so BCD loads split unevenly
                            if (at_tc) begin
                                o_out <= half_r;
                                half_r <= ~half_r;
                                cnt_r <= load_r;
                            end else if (cnt_nxt ==
                                         {1'b0, load_r[15:1]}) begin
                                o_out <= half_r;
                                half_r <= ~half_r;
                            end
                        end
                        default: begin
                            if (at_tc) begin
                                o_out <= 1'b0;
                                armed_r <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_read_valid <= 1'b0;
            o_read_value <= PICM_CNT_ZERO;
        end else begin
            o_read_valid <= i_cmd_valid && i_cmd.op == PICM_OP_READ;
            if (i_cmd_valid && i_cmd.op == PICM_OP_READ) begin
                o_read_value <= cnt_r;
            end
        end
    end

    // Checks kept beside the logic they guard
    sequence s_read_req;
        i_cmd_valid && i_cmd.op == PICM_OP_READ;
    endsequence

    a_read_answer: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        s_read_req |=> o_read_valid && o_read_value == $past(cnt_r))
        else $error("Read did not return count");

    a_reset_level: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_cmd_valid && i_cmd.op == PICM_OP_RESET
        |=> o_out == $past(i_cmd.out_level))
        else $error("Reset level not applied");

    a_rate_pulse: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mode_r == PICM_MODE_RATE && !i_cmd_valid && run && cclk_fall
        && at_tc |=> !o_out && cnt_r == load_r)
        else $error("Rate pulse missing");

    a_strobe_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mode_r == PICM_MODE_SW_STROBE && !i_gate && !i_cmd_valid
        |=> cnt_r == $past(cnt_r))
        else $error("Strobe counted with gate low");

    a_strobe_tc: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mode_r == PICM_MODE_SW_STROBE && !i_cmd_valid && run && cclk_fall
        && at_tc |=> !o_out)
        else $error("Strobe low missing");

    a_mode0_start: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_cmd_valid && i_cmd.op == PICM_OP_MODE0 |=> !o_out && armed_r)
        else $error("Mode 0 start wrong");

    a_count_step: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mode_r == PICM_MODE0 && !i_cmd_valid && run && cclk_fall
        |=> cnt_r == $past(cnt_nxt))
        else $error("Count did not step");

    a_bcd_digit: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !binary_r && cnt_r[3:0] == PICM_DIGIT_ZERO
        |-> cnt_nxt[3:0] == PICM_DIGIT_NINE)
        else $error("BCD borrow wrong");

    a_oneshot_end: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        mode_r == PICM_MODE_ONESHOT && !i_cmd_valid && run && cclk_fall
        && at_tc |=> o_out && !armed_r)
        else $error("One-shot did not end high");

endmodule

// *** picm_counter_bench.sv ***
/*
 * Self-checking bench for the interval counter channel: drives commands,
 * count clocks and gate, and checks output, status and read answers.
 * Assumes the picm_pkg package and picm_counter are compiled before it.
 */
module picm_counter_bench
    import picm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_cmd_valid = 1'b0;
    picm_cmd_t i_cmd = '0;
    logic i_gate = 1'b0;
    logic [3:0] src = 4'h0;
    logic [1:0] sel = 2'h0;
    logic o_out;
    logic o_tc_pulse;
    logic o_read_valid;
    logic [15:0] o_read_value;
    int fails = 0;
    int n_checks = 0;
    logic seen_tc;
    logic out_v;
    logic hist [0:11];
    int first;

    picm_counter u_picm_counter (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_cmd_valid(i_cmd_valid),
        .i_cmd(i_cmd),
        .i_external_count_clock(src[0]),
        .i_previous_counter_output(src[1]),
        .i_internal_count_clock(src[2]),
        .i_counter_ten_output(src[3]),
        .i_gate(i_gate),
        .o_out(o_out),
        .o_tc_pulse(o_tc_pulse),
        .o_read_valid(o_read_valid),
        .o_read_value(o_read_value)
    );

    initial begin
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    task automatic print_verdict;
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic send(input logic [2:0] op, input logic [15:0] cnt,
                        input logic lvl, input logic bin, input logic [1:0] s);
        @(negedge i_clk_sys);
        i_cmd_valid = 1'b1;
        i_cmd = '{op, cnt, lvl, bin, s};
        if (op < PICM_OP_READ) begin
            sel = s;
        end
        @(negedge i_clk_sys);
        i_cmd_valid = 1'b0;
    endtask

    task automatic read_chk(input logic [15:0] exp);
        send(PICM_OP_READ, 16'h0000, 1'b0, 1'b1, sel);
        check("read_valid", o_read_valid, 16'h0001);
        check("read_value", o_read_value, exp);
        @(negedge i_clk_sys);
        check("read_valid_drop", o_read_valid, 16'h0000);
    endtask

    // Only the selected source toggles, so a wrong clock mux never counts
    task automatic fall;
        @(negedge i_clk_sys);
        src[sel] = 1'b1;
        @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        src[sel] = 1'b0;
        @(negedge i_clk_sys);
        seen_tc = o_tc_pulse;
        out_v = o_out;
    endtask

    task automatic fall_to_tc;
        seen_tc = 1'b0;
        for (int k = 0; k < 4 && seen_tc !== 1'b1; k++) begin
            fall();
        end
        check("tc_seen", seen_tc, 16'h0001);
    endtask

    initial begin
        repeat (3) @(negedge i_clk_sys);
        check("rst_out", o_out, 16'h0001);
        check("rst_tc", o_tc_pulse, 16'h0000);
        check("rst_rvalue", o_read_value, 16'h0000);
        check("rst_rvalid", o_read_valid, 16'h0000);
        i_rst_n = 1'b1;
        send(PICM_OP_RESET, 16'h0000, 1'b0, 1'b1, PICM_SRC_EXT);
        check("reset_low", o_out, 16'h0000);
        send(PICM_OP_RESET, 16'h0000, 1'b1, 1'b1, PICM_SRC_EXT);
        check("reset_high", o_out, 16'h0001);
        send(PICM_OP_RESET, 16'h0000, 1'b0, 1'b1, PICM_SRC_EXT);
        // Level 0 with a mode code must not force the output low
        send(PICM_OP_SW_STROBE, 16'h0002, 1'b0, 1'b1, PICM_SRC_EXT);
        check("sw_start", o_out, 16'h0001);
        fall();
        read_chk(16'h0002);
        i_gate = 1'b1;
        fall();
        read_chk(16'h0001);
        fall();
        check("sw_tc", seen_tc, 16'h0001);
        check("sw_low", out_v, 16'h0000);
        fall();
        check("sw_back", out_v, 16'h0001);
        send(PICM_OP_SW_STROBE, 16'h0010, 1'b1, 1'b0, PICM_SRC_INT);
        fall();
        read_chk(16'h0009);
        send(PICM_OP_SW_STROBE, 16'h0010, 1'b1, 1'b1, PICM_SRC_INT);
        fall();
        read_chk(16'h000F);
        send(PICM_OP_RATE, 16'h0003, 1'b1, 1'b1, PICM_SRC_PREV);
        for (int k = 0; k < 12; k++) begin
            fall();
            hist[k] = out_v;
        end
        // Load 3: the third count fall is the terminal step
        first = 2;
        for (int k = 0; k < 12; k++) begin
            check("rate_out", hist[k], {15'h0, (k % 3) != (first % 3)});
        end
        send(PICM_OP_SQUARE, 16'h0004, 1'b1, 1'b1, PICM_SRC_TEN);
        for (int k = 0; k < 10; k++) begin
            fall();
            hist[k] = out_v;
        end
        for (int k = 2; k < 8; k++) begin
            check("square_out", hist[k + 2], {15'h0, ~hist[k]});
        end
        i_gate = 1'b0;
        send(PICM_OP_ONESHOT, 16'h0002, 1'b1, 1'b1, PICM_SRC_EXT);
        fall();
        check("os_idle", out_v, 16'h0001);
        i_gate = 1'b1;
        fall();
        check("os_low", out_v, 16'h0000);
        fall_to_tc();
        check("os_high", out_v, 16'h0001);
        i_gate = 1'b0;
        send(PICM_OP_HW_STROBE, 16'h0002, 1'b1, 1'b1, PICM_SRC_INT);
        fall();
        fall();
        fall();
        check("hw_wait", seen_tc, 16'h0000);
        check("hw_wait_out", out_v, 16'h0001);
        i_gate = 1'b1;
        fall_to_tc();
        check("hw_low", out_v, 16'h0000);
        fall();
        check("hw_back", out_v, 16'h0001);
        send(PICM_OP_MODE0, 16'h0001, 1'b1, 1'b1, PICM_SRC_EXT);
        check("m0_low", o_out, 16'h0000);
        fall_to_tc();
        check("m0_high", out_v, 16'h0001);
        send(PICM_OP_RESET, 16'h0000, 1'b0, 1'b1, PICM_SRC_EXT);
        check("reset_low2", o_out, 16'h0000);
        i_rst_n = 1'b0;
        @(negedge i_clk_sys);
        check("rst2_out", o_out, 16'h0001);
        check("rst2_rvalue", o_read_value, 16'h0000);
        i_rst_n = 1'b1;
        read_chk(16'h0000);
        print_verdict();
    end

    // Tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        fails++;
        print_verdict();
    end
endmodule

// *** picm_pkg.sv ***
/*
 * Package for the programmable interval counter channel: operation codes,
 * clock source codes, the command carrier and reset values.
 * Assumes a single system clock; count clocks are sampled as plain inputs.
 */
package picm_pkg;

    localparam int PICM_CNT_W = 16;

    // Operation codes carried with each command
    localparam logic [2:0] PICM_OP_MODE0 = 3'h0;
    localparam logic [2:0] PICM_OP_ONESHOT = 3'h1;
    localparam logic [2:0] PICM_OP_RATE = 3'h2;
    localparam logic [2:0] PICM_OP_SQUARE = 3'h3;
    localparam logic [2:0] PICM_OP_SW_STROBE = 3'h4;
    localparam logic [2:0] PICM_OP_HW_STROBE = 3'h5;
    localparam logic [2:0] PICM_OP_READ = 3'h6;
    localparam logic [2:0] PICM_OP_RESET = 3'h7;

    // Count clock sources
    localparam logic [1:0] PICM_SRC_EXT = 2'h0;
    localparam logic [1:0] PICM_SRC_PREV = 2'h1;
    localparam logic [1:0] PICM_SRC_INT = 2'h2;
    localparam logic [1:0] PICM_SRC_TEN = 2'h3;

    // Counter arithmetic constants
    localparam logic [15:0] PICM_CNT_ZERO = 16'h0000;
    localparam logic [15:0] PICM_CNT_ONE = 16'h0001;
    localparam logic [15:0] PICM_BIN_TOP = 16'hFFFF;
    localparam logic [15:0] PICM_BCD_TOP = 16'h9999;
    localparam logic [3:0] PICM_DIGIT_NINE = 4'h9;
    localparam logic [3:0] PICM_DIGIT_ZERO = 4'h0;
    localparam logic [3:0] PICM_DIGIT_ONE = 4'h1;

    // Reset values
    localparam logic PICM_BINARY_DEFAULT = 1'b1;
    localparam logic PICM_OUT_IDLE = 1'b1;

    typedef enum logic [5:0] {
        PICM_MODE0 = 6'b000001,
        PICM_MODE_ONESHOT = 6'b000010,
        PICM_MODE_RATE = 6'b000100,
        PICM_MODE_SQUARE = 6'b001000,
        PICM_MODE_SW_STROBE = 6'b010000,
        PICM_MODE_HW_STROBE = 6'b100000
    } picm_mode_t;

    // One command from software, valid for the cycle of i_cmd_valid
    typedef struct packed {
        logic [2:0] op;
        logic [15:0] count;
        logic out_level;
        logic binary_sel;
        logic [1:0] clk_src;
    } picm_cmd_t;

endpackage
